/* design/brownout_reset_flags.v */
/*
 * Brown-out reset control register and reset-cause flag register.
 * Assumes a single 125 MHz clock, an asynchronous active-low reset,
 * a plain register port with one-cycle read latency, and reset-cause
 * pulses that arrive from the reset sequencer outside this block.
 */
`timescale 1ns/10ps
`include "brownout_defs.vh"

//////////////////////////////////////////////////////////////////////
module brownout_reset_flags #(
   parameter ADDR_W = 8
) (
   input wire clk,
   input wire rst_b,
   input wire [ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [1:0] brownout_config_mode,
   input wire hw_brownout_on,
   input wire circuit_ready_pin,
   input wire [`CAUSE_W-1:0] cause_event,
   output wire brownout_reset_en,
   output wire irq
);

   //////////////////////////////////////////////////////////////////
   // Input synchronisers.

   // The ready level comes from the analog circuit, another domain.
   reg rdy_s1_ff;
   reg rdy_s2_ff;

   // Two-stage catch of the ready level; only stage two is read.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdy_s1_ff <= 1'b0;
         rdy_s2_ff <= 1'b0;
      end else begin
         rdy_s1_ff <= circuit_ready_pin;
         rdy_s2_ff <= rdy_s1_ff;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Register state.

   // Software brown-out enable, resets to enabled.
   reg sw_brownout_enable_ff;
   // Reserved bit, stored as written so software sees what it wrote.
   reg rsvd_ff;
   // Sticky reset-cause flags.
   reg [`CAUSE_W-1:0] reset_cause_register_ff;
   // Interrupt status and mask.
   reg [`CAUSE_W-1:0] irq_stat_ff;
   reg [`CAUSE_W-1:0] irq_mask_ff;

   // Decoded write strobes.
   wire wr_ctrl = reg_wr && (reg_addr == `BO_CTRL_OFS);
   wire wr_cause = reg_wr && (reg_addr == `BO_CAUSE_OFS);
   wire wr_stat = reg_wr && (reg_addr == `BO_IRQ_STAT_OFS);
   wire wr_mask = reg_wr && (reg_addr == `BO_IRQ_MASK_OFS);

   //////////////////////////////////////////////////////////////////
   // Brown-out enable selection.

   // Only configuration mode 01 hands control to software; other modes
   // follow the fixed configuration input instead.
   assign brownout_reset_en = (brownout_config_mode == `BO_MODE_SW) ?
      sw_brownout_enable_ff :
      hw_brownout_on;

   //////////////////////////////////////////////////////////////////
   // Control register writes.

   // Bits five to one have no storage, so writes to them vanish.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_brownout_enable_ff <= `BO_SWEN_RST;
         rsvd_ff <= 1'b0;
      end else if (wr_ctrl) begin
         sw_brownout_enable_ff <= reg_wdata[`BO_CTRL_SWEN_BIT];
         // Software is expected to write zero here; it is kept as written.
         rsvd_ff <= reg_wdata[`BO_CTRL_RSVD_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////
   // Reset-cause flags.

   // Each flag is set by its own cause pulse and otherwise holds.
   // A software write stores the whole field, so software clears flags
   // and may also set them for testing; nothing here issues a reset.
   // A cause pulse in the same cycle as a write wins over the write.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_cause_register_ff <= `CAUSE_RST;
      end else if (wr_cause) begin
         reset_cause_register_ff <= reg_wdata[`CAUSE_W-1:0] | cause_event;
      end else begin
         reset_cause_register_ff <= reset_cause_register_ff | cause_event;
      end
   end

   //////////////////////////////////////////////////////////////////
   // Interrupt status and mask.

   // Each cause event also sets a sticky status bit; writing one clears
   // it, and a new event in that same cycle keeps it set.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_ff <= `CAUSE_RST;
         irq_mask_ff <= `IRQ_MASK_RST;
      end else begin
         if (wr_stat) begin
            irq_stat_ff <= (irq_stat_ff & ~reg_wdata[`CAUSE_W-1:0]) | cause_event;
         end else begin
            irq_stat_ff <= irq_stat_ff | cause_event;
         end
         if (wr_mask) begin
            irq_mask_ff <= reg_wdata[`CAUSE_W-1:0];
         end
      end
   end

   // Level interrupt while any unmasked status bit stands.
   assign irq = |(irq_stat_ff & irq_mask_ff);

   //////////////////////////////////////////////////////////////////
   // Read data path.

   // Read data stands for exactly the cycle after the read strobe and
   // is zero otherwise, including for unmapped addresses.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `BO_CTRL_OFS: begin
               // Bits five to one read zero.
               reg_rdata <= {24'h000000, sw_brownout_enable_ff, rsvd_ff, 5'h00,
                  rdy_s2_ff};
            end
            `BO_CAUSE_OFS: begin
               reg_rdata <= {25'h0000000, reset_cause_register_ff};
            end
            `BO_IRQ_STAT_OFS: begin
               reg_rdata <= {25'h0000000, irq_stat_ff};
            end
            `BO_IRQ_MASK_OFS: begin
               reg_rdata <= {25'h0000000, irq_mask_ff};
            end
            default: begin
               reg_rdata <= 32'h00000000;
            end
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule

/* design/brownout_defs.vh */
/*
 * Constants for the brown-out control and reset-cause flag block:
 * register offsets, field positions, reset values and encodings.
 * Assumes it is included by its bare name from design files only.
 */
`ifndef BROWNOUT_DEFS_VH
`define BROWNOUT_DEFS_VH

// Register byte offsets on the plain register port.
`define BO_CTRL_OFS 8'h00
`define BO_CAUSE_OFS 8'h04
`define BO_IRQ_STAT_OFS 8'h08
`define BO_IRQ_MASK_OFS 8'h0c

// Brown-out control register fields.
`define BO_CTRL_SWEN_BIT 7
`define BO_CTRL_RSVD_BIT 6
`define BO_CTRL_RDY_BIT 0

// Configuration mode in which the software enable steers the circuit.
`define BO_MODE_SW 2'h1

// Reset-cause flag positions (a flag reads 1 when active).
`define CAUSE_POR_BIT 0
`define CAUSE_BOR_BIT 1
`define CAUSE_RI_BIT 2
`define CAUSE_CLR_BIT 3
`define CAUSE_WDT_BIT 4
`define CAUSE_UNF_BIT 5
`define CAUSE_OVF_BIT 6
`define CAUSE_W 7

// Reset values.
`define BO_SWEN_RST 1'h1
`define CAUSE_RST 7'h00
`define IRQ_MASK_RST 7'h00

`endif

/* tb/brownout_flags_monitor.sv */
/* Checker for the brown-out control and reset-cause flag block.
   Assumes it sees only the top ports and is attached by bind. */
`timescale 1ns/10ps
module brownout_flags_monitor #(parameter ADDR_W = 8) (
   input wire clk, input wire rst_b, input wire [ADDR_W-1:0] reg_addr,
   input wire [31:0] reg_wdata, input wire reg_wr, input wire reg_rd,
   input wire [31:0] reg_rdata, input wire [1:0] brownout_config_mode,
   input wire hw_brownout_on, input wire circuit_ready_pin,
   input wire [6:0] cause_event, input wire brownout_reset_en, input wire irq);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire rd_c = reg_rd && reg_addr == 8'h00;
   wire rd_f = reg_rd && reg_addr == 8'h04;
   // In software mode the enable follows bit 7 of a control write one cycle later.
   a_mode_sw_en: assert property ((reg_wr && reg_addr == 8'h00 && brownout_config_mode == 2'h1)
      ##1 brownout_config_mode == 2'h1 |-> brownout_reset_en == $past(reg_wdata[7]))
      else $error("sw enable not applied");
   a_mode_hw_en: assert property (brownout_config_mode != 2'h1 |->
      brownout_reset_en == hw_brownout_on) else $error("sw enable not ignored");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero");
   a_ctrl_zero_bits: assert property (rd_c |=> reg_rdata[5:1] == 5'h00)
      else $error("unused bits not zero");
   a_ready_status: assert property (rd_c && $stable(circuit_ready_pin)
      && $past($stable(circuit_ready_pin)) |=> reg_rdata[0] == $past(circuit_ready_pin))
      else $error("ready bit wrong");
   a_flag_set: assert property (cause_event != 7'h00 ##1 rd_f |=>
      (reg_rdata[6:0] & $past(cause_event, 2)) == $past(cause_event, 2))
      else $error("cause flag not set");
   a_flag_write: assert property ((reg_wr && reg_addr == 8'h04 && cause_event == 7'h00)
      ##1 (rd_f && cause_event == 7'h00) |=> reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
      else $error("flag write lost");
   a_unmapped_zero: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   c_cause: cover property (cause_event != 7'h00 ##1 rd_f);
   c_irq: cover property ($rose(irq));
   c_sw_mode: cover property (brownout_config_mode == 2'h1 && !brownout_reset_en);
endmodule
bind brownout_reset_flags brownout_flags_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

/* tb/testbench.sv */
/* Self-checking bench for the brown-out and reset-cause flag block.
   Assumes the design drives read data one cycle after the strobe. */
`timescale 1ns/10ps
module testbench;
   reg clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, hw_on = 0, rdy = 1;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0;
   reg [1:0] mode = 2'h1;
   reg [6:0] ev = 7'h00, acc;
   wire [31:0] rdata;
   wire en, irq;
   integer error_cnt = 0, n_compared = 0, i;
   always #4 clk = ~clk;
   brownout_reset_flags DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
      .brownout_config_mode(mode), .hw_brownout_on(hw_on), .circuit_ready_pin(rdy),
      .cause_event(ev), .brownout_reset_en(en), .irq(irq));
   ////////////////////////////////////////////////////////////////
   // Shared compare and bus tasks.
   task chk(input [31:0] s, input [31:0] e);
      n_compared = n_compared + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
      @(posedge clk) reg_wr <= 0;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      @(posedge clk) begin reg_rd <= 1; reg_addr <= a; end
      @(posedge clk) reg_rd <= 0;
      #1 chk(rdata, e);
   endtask
   task pulse(input [6:0] p);
      @(posedge clk) ev <= p;
      @(posedge clk) ev <= 7'h00;
   endtask
   ////////////////////////////////////////////////////////////////
   // Control register: enable steering, ready bit, unused bits.
   task t_ctrl;
      rd(8'h00, 32'h81);
      wr(8'h00, 32'hbe);
      rd(8'h00, 32'h81);
      wr(8'h00, 32'h00);
      #1 chk(en, 0);
      wr(8'h00, 32'h80);
      #1 chk(en, 1);
      @(posedge clk) mode <= 2'h2;
      #1 chk(en, 0);
      @(posedge clk) rdy <= 0;
      wr(8'h00, 32'h00);
      rd(8'h00, 32'h00);
      @(posedge clk) mode <= 2'h1;
   endtask
   // Each cause sets only its own flag; flags persist and accept writes.
   task t_cause;
      acc = 7'h00;
      for (i = 0; i < 7; i = i + 1) begin
         pulse(7'h01 << i);
         acc = acc | (7'h01 << i);
         rd(8'h04, acc);
      end
      repeat (5) @(posedge clk);
      rd(8'h04, 32'h7f);
      wr(8'h04, 32'h00);
      rd(8'h04, 32'h00);
      wr(8'h04, 32'h7f);
      rd(8'h04, 32'h7f);
      chk(rst_b, 1);
   endtask
   // Sticky status, mask and clear-by-one of the interrupt.
   task t_irq;
      wr(8'h08, 32'h7f);
      wr(8'h0c, 32'h10);
      pulse(7'h10);
      #1 chk(irq, 1);
      wr(8'h0c, 32'h00);
      #1 chk(irq, 0);
      wr(8'h0c, 32'h10);
      wr(8'h08, 32'h10);
      #1 chk(irq, 0);
      rd(8'h10, 32'h0);
   endtask
   task final_report;
      if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1;
      repeat (2) @(posedge clk);
      t_ctrl;
      t_cause;
      t_irq;
      final_report;
   end
endmodule
